// ### pcs_core.sv
// Program counter, return stack and indirect pointer decode unit
`timescale 1ns/1ps

// Overview of operation
// - Program counter is fifteen bits; low byte software accessible, upper bits not.
// - Every reset clears the whole program counter.
// - Writing the low byte loads the upper bits from the high latch.
// - Absolute call: low byte and bits 10..8 from operand, rest latch.
// - Computed call: low byte from accumulator, upper bits from latch.
// - Accumulator branch: counter becomes incremented counter plus unsigned accumulator.
// - Operand branch: counter becomes incremented counter plus signed operand.
// - Sixteen fifteen-bit stack entries, outside program and data spaces.
// - Push on calls and interrupt; pop on the three returns.
// - Pushes and pops never change the high latch.
// - Without error reset the stack wraps around circularly.
// - Overflow and underflow flags set whether or not reset enabled.
// - Software moves the pointer and reads or writes the selected entry.
// - Stack pointer is five bits wide.
// - Push increments then stores; pop reloads then decrements.
// - With error reset enabled, overflow or underflow resets and flags.
// - Window accesses go to the address in the pointer pair.
// - Pointer naming a window reads zero and drops the write.
// - Pointer pair is a sixteen-bit address over three regions.
// - Up to 0FFF traditional, 1000 to 1FFF reserved, linear from 2000.
// - Addresses from 8000 map onto program memory from zero.
// - Linear region ends at 29AF, mapping onto 80-byte bank blocks.
// - Program reads return low byte, reject writes, add a cycle.
module pcs_core
	import pcs_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [31:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        seq_advance,
	input  wire logic        seq_pcl_write,
	input  wire logic [7:0]  seq_pcl_data,
	input  wire logic        seq_call,
	input  wire logic [10:0] seq_call_operand,
	input  wire logic        seq_call_via_accum,
	input  wire logic        seq_jump_rel_accum,
	input  wire logic        seq_jump_rel_signed,
	input  wire logic [8:0]  seq_branch_operand,
	input  wire logic        seq_vector,
	input  wire logic [14:0] seq_vector_addr,
	input  wire logic        seq_return,
	input  wire logic [7:0]  seq_accum,
	input  wire logic        win_sel,
	output logic      [14:0] pc,
	output logic             stack_reset_req,
	output logic      [1:0]  win_region,
	output logic      [15:0] win_target,
	output logic             win_self,
	output logic             win_write_ok,
	output logic             win_extra_cycle
);

	logic [14:0] pc_q;
	logic [6:0]  pc_high_latch_q;
	logic [4:0]  sp_q;
	logic [14:0] stack_mem [DEPTH];
	logic        stack_error_reset_enable_q;
	logic        ovf_q;
	logic        unf_q;
	logic [7:0]  sav_q [8];
	logic [7:0]  ptr_q [4];
	logic        rst_req_q;

	logic        wr_en;
	logic        rd_en;
	logic [11:0] reg_idx;
	logic        addr_ok;
	logic [14:0] pc_inc;
	logic        push;
	logic        pop;
	logic        sw_pcl_wr;
	logic        hit_sav;
	logic [3:0]  sp_slot;

	// APB: zero-wait slave, index is byte address over four
	assign reg_idx = paddr[13:2];
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign hit_sav = (reg_idx >= IDX_FLAGS_SAV) && (reg_idx <= IDX_P1H_SAV);
	assign addr_ok = hit_sav || (reg_idx >= IDX_STK_IDX
		&& reg_idx <= IDX_TOS_HI) || (reg_idx <= IDX_PCNOW_HI
		&& reg_idx >= IDX_CTRL);
	assign pslverr = psel & penable & ~addr_ok;

	assign pc_inc    = pc_q + 15'h0001;
	assign push      = seq_call | seq_call_via_accum | seq_vector;
	assign pop       = seq_return;
	assign sw_pcl_wr = wr_en && reg_idx == IDX_PCL;
	assign sp_slot   = sp_q[3:0];
	assign pc        = pc_q;

	// Program counter load; sequencer events other than advance beat software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_q <= 15'h0000;
		end else if (rst_req_q) begin
			pc_q <= 15'h0000;
		end else if (seq_vector) begin
			pc_q <= seq_vector_addr;
		end else if (seq_call) begin
			pc_q <= {pc_high_latch_q[6:3], seq_call_operand};
		end else if (seq_call_via_accum) begin
			pc_q <= {pc_high_latch_q, seq_accum};
		end else if (seq_jump_rel_accum) begin
			pc_q <= pc_inc + {7'h00, seq_accum};
		end else if (seq_jump_rel_signed) begin
			pc_q <= pc_inc + {{6{seq_branch_operand[8]}},
				seq_branch_operand};
		end else if (pop) begin
			pc_q <= stack_mem[sp_slot];
		end else if (seq_pcl_write) begin
			pc_q <= {pc_high_latch_q, seq_pcl_data};
		end else if (sw_pcl_wr) begin
			pc_q <= {pc_high_latch_q, pwdata[7:0]};
		end else if (seq_advance) begin
			pc_q <= pc_inc;
		end
	end

	// High latch: software only, stack traffic leaves it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_high_latch_q <= 7'h00;
		end else if (wr_en && reg_idx == IDX_PC_HIGH_LATCH) begin
			pc_high_latch_q <= pwdata[6:0];
		end
	end

	// Stack pointer: five bits, wraps modulo sixteen slots
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sp_q <= SP_RESET;
		end else if (rst_req_q) begin
			sp_q <= SP_RESET;
		end else if (push) begin
			if (sp_q == SP_TOP)
				sp_q <= stack_error_reset_enable_q ? SP_OVER : 5'h00;
			else
				sp_q <= sp_q + 5'h01;
		end else if (pop) begin
			sp_q <= sp_q - 5'h01;
		end else if (wr_en && reg_idx == IDX_STK_IDX) begin
			sp_q <= pwdata[4:0];
		end
	end

	// Stack array: push writes the slot after increment
	always_ff @(posedge pclk) begin
		if (push) begin
			stack_mem[sp_slot + 4'h1] <= (seq_vector ? pc_q : pc_inc);
		end else if (wr_en && reg_idx == IDX_TOS_LO) begin
			stack_mem[sp_slot][7:0] <= pwdata[7:0];
		end else if (wr_en && reg_idx == IDX_TOS_HI) begin
			stack_mem[sp_slot][14:8] <= pwdata[6:0];
		end
	end

	// Error flags; hardware set beats software clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
			unf_q <= 1'b0;
		end else begin
			if (push && sp_q == SP_TOP)
				ovf_q <= 1'b1;
			else if (wr_en && reg_idx == IDX_CAUSE)
				ovf_q <= pwdata[CAUSE_OVF_BIT];
			if (pop && sp_q == 5'h00)
				unf_q <= 1'b1;
			else if (wr_en && reg_idx == IDX_CAUSE)
				unf_q <= pwdata[CAUSE_UNF_BIT];
		end
	end

	// Reset request one cycle after the fault when enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rst_req_q <= 1'b0;
		else
			rst_req_q <= stack_error_reset_enable_q && ((push && sp_q == SP_TOP)
				|| (pop && sp_q == 5'h00));
	end
	assign stack_reset_req = rst_req_q;

	// Control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stack_error_reset_enable_q <= 1'b0;
		else if (wr_en && reg_idx == IDX_CTRL)
			stack_error_reset_enable_q <= pwdata[CTRL_STACK_ERROR_RESET_ENABLE_BIT];
	end

	// Saved copies and pointer pairs, one byte each
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_sav
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					sav_q[gi] <= 8'h00;
				else if (wr_en && reg_idx == IDX_FLAGS_SAV + 12'(gi))
					sav_q[gi] <= pwdata[7:0];
			end
		end
		for (gi = 0; gi < 4; gi++) begin : g_ptr
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn)
					ptr_q[gi] <= 8'h00;
				else if (wr_en && reg_idx == IDX_PTR0_LO + 12'(gi))
					ptr_q[gi] <= pwdata[7:0];
			end
		end
	endgenerate

	// Read mux; unimplemented bits read zero
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (reg_idx)
				IDX_FLAGS_SAV: prdata[2:0] = sav_q[0][2:0];
				IDX_ACC_SAV:   prdata[7:0] = sav_q[1];
				IDX_BSR_SAV:   prdata[4:0] = sav_q[2][4:0];
				IDX_PCH_SAV:   prdata[6:0] = sav_q[3][6:0];
				IDX_P0L_SAV:   prdata[7:0] = sav_q[4];
				IDX_P0H_SAV:   prdata[7:0] = sav_q[5];
				IDX_P1L_SAV:   prdata[7:0] = sav_q[6];
				IDX_P1H_SAV:   prdata[7:0] = sav_q[7];
				IDX_STK_IDX:   prdata[4:0] = sp_q;
				IDX_TOS_LO:    prdata[7:0] = stack_mem[sp_slot][7:0];
				IDX_TOS_HI:    prdata[6:0] = stack_mem[sp_slot][14:8];
				IDX_CTRL:      prdata[0]   = stack_error_reset_enable_q;
				IDX_PCL:       prdata[7:0] = pc_q[7:0];
				IDX_PC_HIGH_LATCH:    prdata[6:0] = pc_high_latch_q;
				IDX_CAUSE: begin
					prdata[CAUSE_OVF_BIT] = ovf_q;
					prdata[CAUSE_UNF_BIT] = unf_q;
				end
				IDX_PTR0_LO:   prdata[7:0] = ptr_q[0];
				IDX_PTR0_HI:   prdata[7:0] = ptr_q[1];
				IDX_PTR1_LO:   prdata[7:0] = ptr_q[2];
				IDX_PTR1_HI:   prdata[7:0] = ptr_q[3];
				default:       prdata = 32'h0000_0000;
			endcase
		end
	end

	// Indirect decode for the selected pointer pair
	logic [15:0] fsr;
	logic [15:0] lin_off;
	logic [7:0]  lin_bank;
	logic [6:0]  lin_pos;
	assign fsr = win_sel ? {ptr_q[3], ptr_q[2]} : {ptr_q[1], ptr_q[0]};
	assign lin_off  = fsr - LIN_BASE;
	assign lin_bank = 8'(lin_off / {8'h00, LIN_BLOCK});
	assign lin_pos  = 7'(lin_off % {8'h00, LIN_BLOCK});

	always_comb begin
		win_region = PCS_RGN_RSVD;
		win_target = 16'h0000;
		if (fsr >= PROG_BASE) begin
			win_region = PCS_RGN_PROG;
			win_target = {1'b0, fsr[14:0]};
		end else if (fsr <= TRAD_END) begin
			win_region = PCS_RGN_TRAD;
			win_target = fsr;
		end else if (fsr >= LIN_BASE && fsr <= LIN_END) begin
			win_region = PCS_RGN_LIN;
			win_target = {1'b0, lin_bank, BANK_SIZE}
				+ {8'h00, BANK_GPR} + {9'h000, lin_pos};
		end
	end

	// Self reference reads zero; program region read only
	assign win_self = (fsr == WIN0_ADDR) || (fsr == WIN1_ADDR);
	assign win_write_ok = ~win_self && (win_region == PCS_RGN_TRAD
		|| win_region == PCS_RGN_LIN);
	assign win_extra_cycle = (win_region == PCS_RGN_PROG);

endmodule // pcs_core

// ### pcs_pkg.sv
// Package of constants for the program counter, stack and pointer unit
package pcs_pkg;
	localparam int PC_W   = 15;
	localparam int SP_W   = 5;
	localparam int DEPTH  = 16;
	localparam int ADDR_W = 12;
	// Register indices, byte address over four (printed offsets not multiples of four)
	localparam logic [11:0] IDX_FLAGS_SAV = 12'hFE4;
	localparam logic [11:0] IDX_ACC_SAV   = 12'hFE5;
	localparam logic [11:0] IDX_BSR_SAV   = 12'hFE6;
	localparam logic [11:0] IDX_PCH_SAV   = 12'hFE7;
	localparam logic [11:0] IDX_P0L_SAV   = 12'hFE8;
	localparam logic [11:0] IDX_P0H_SAV   = 12'hFE9;
	localparam logic [11:0] IDX_P1L_SAV   = 12'hFEA;
	localparam logic [11:0] IDX_P1H_SAV   = 12'hFEB;
	localparam logic [11:0] IDX_STK_IDX   = 12'hFED;
	localparam logic [11:0] IDX_TOS_LO    = 12'hFEE;
	localparam logic [11:0] IDX_TOS_HI    = 12'hFEF;
	// Own registers: control, counter, flags and pointers
	localparam logic [11:0] IDX_CTRL      = 12'hF00;
	localparam logic [11:0] IDX_PCL       = 12'hF01;
	localparam logic [11:0] IDX_PC_HIGH_LATCH    = 12'hF02;
	localparam logic [11:0] IDX_CAUSE     = 12'hF03;
	localparam logic [11:0] IDX_PTR0_LO   = 12'hF04;
	localparam logic [11:0] IDX_PTR0_HI   = 12'hF05;
	localparam logic [11:0] IDX_PTR1_LO   = 12'hF06;
	localparam logic [11:0] IDX_PTR1_HI   = 12'hF07;
	localparam logic [11:0] IDX_PCNOW_HI  = 12'hF08;
	// Field positions and reset values
	localparam int CTRL_STACK_ERROR_RESET_ENABLE_BIT = 0;
	localparam int CAUSE_OVF_BIT   = 7;
	localparam int CAUSE_UNF_BIT   = 6;
	localparam logic [4:0] SP_RESET = 5'h1F;
	localparam logic [4:0] SP_TOP   = 5'h0F;
	localparam logic [4:0] SP_OVER  = 5'h10;
	// Pointer address map
	localparam logic [15:0] TRAD_END  = 16'h0FFF;
	localparam logic [15:0] LIN_BASE  = 16'h2000;
	localparam logic [15:0] LIN_END   = 16'h29AF;
	localparam logic [15:0] PROG_BASE = 16'h8000;
	localparam logic [15:0] WIN0_ADDR = 16'h0000;
	localparam logic [15:0] WIN1_ADDR = 16'h0001;
	localparam logic [7:0]  LIN_BLOCK = 8'h50;
	localparam logic [7:0]  BANK_GPR  = 8'h20;
	localparam logic [6:0]  BANK_SIZE = 7'h00;
	// Region codes
	typedef enum logic [1:0] {
		PCS_RGN_TRAD = 2'h0,
		PCS_RGN_LIN  = 2'h1,
		PCS_RGN_PROG = 2'h3,
		PCS_RGN_RSVD = 2'h2
	} pcs_region_t;
endpackage

// ### pcs_core_asserts.sv
// Port assertions for the program counter, stack and pointer unit
`timescale 1ns/1ps
module pcs_core_asserts
	import pcs_pkg::*;
(
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pslverr,
	input logic        seq_call,
	input logic [10:0] seq_call_operand,
	input logic        seq_call_via_accum,
	input logic        seq_jump_rel_accum,
	input logic        seq_jump_rel_signed,
	input logic [8:0]  seq_branch_operand,
	input logic        seq_vector,
	input logic [7:0]  seq_accum,
	input logic [14:0] pc,
	input logic        stack_reset_req,
	input logic [1:0]  win_region,
	input logic        win_self,
	input logic        win_write_ok,
	input logic        win_extra_cycle
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Higher-priority loads mask the lower ones
	logic        hi_c, hi_w, hi_r;
	logic [14:0] bop_x;
	assign hi_c = seq_vector || stack_reset_req;
	assign hi_w = hi_c || seq_call;
	assign hi_r = hi_w || seq_call_via_accum;
	assign bop_x = {{6{seq_branch_operand[8]}}, seq_branch_operand};
	property p_call; seq_call && !hi_c |=>
		pc[10:0] == $past(seq_call_operand); endproperty
	a_call: assert property (p_call) else $error("call target");
	property p_call_via_accum; seq_call_via_accum && !hi_w |=>
		pc[7:0] == $past(seq_accum); endproperty
	a_call_via_accum: assert property (p_call_via_accum) else $error("call_via_accum target");
	property p_brw; seq_jump_rel_accum && !hi_r |=>
		pc == 15'($past(pc) + 15'h1 + $past(seq_accum)); endproperty
	a_brw: assert property (p_brw) else $error("brw target");
	property p_bra; seq_jump_rel_signed && !hi_r && !seq_jump_rel_accum
		|=> pc == 15'($past(pc) + 15'h1 + $past(bop_x)); endproperty
	a_bra: assert property (p_bra) else $error("bra target");
	property p_srr; stack_reset_req |=> pc == 15'h0 && !stack_reset_req;
	endproperty
	a_srr: assert property (p_srr) else $error("stack reset");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("error outside access");
	property p_prog; win_region == PCS_RGN_PROG |->
		!win_write_ok && win_extra_cycle; endproperty
	a_prog: assert property (p_prog) else $error("program window");
	property p_self; win_self |->
		!win_write_ok && win_region == PCS_RGN_TRAD; endproperty
	a_self: assert property (p_self) else $error("self window");
	c_srr: cover property (stack_reset_req);
	c_self: cover property (win_self);
	c_neg: cover property (seq_jump_rel_signed && seq_branch_operand[8]);
endmodule // pcs_core_asserts

// ### pcs_seq_model.sv
// Sequencer model issuing one program counter event per call
`timescale 1ns/1ps
module pcs_seq_model (
	input  logic        pclk,
	output logic        seq_advance,
	output logic        seq_pcl_write,
	output logic [7:0]  seq_pcl_data,
	output logic        seq_call,
	output logic [10:0] seq_call_operand,
	output logic        seq_call_via_accum,
	output logic        seq_jump_rel_accum,
	output logic        seq_jump_rel_signed,
	output logic [8:0]  seq_branch_operand,
	output logic        seq_vector,
	output logic [14:0] seq_vector_addr,
	output logic        seq_return,
	output logic [7:0]  seq_accum
);
	logic [7:0]  hot = 8'h00;
	logic [14:0] arg = 15'h0000;
	logic [7:0]  acc = 8'h00;
	// One-hot event pulses, bit number is the kind code
	assign {seq_return, seq_vector, seq_jump_rel_signed, seq_jump_rel_accum,
		seq_call_via_accum, seq_call, seq_pcl_write, seq_advance} = hot;
	assign seq_call_operand = arg[10:0];
	assign seq_branch_operand = arg[8:0];
	assign seq_vector_addr = arg;
	assign seq_pcl_data = acc;
	assign seq_accum = acc;
	// Operands go inverted when idle so stale values are never trusted
	task automatic go(input int k, input logic [14:0] a, input logic [7:0] w);
		@(posedge pclk);
		hot <= 8'h01 << k;
		arg <= a;
		acc <= w;
		@(posedge pclk);
		hot <= 8'h00;
		arg <= ~a;
		acc <= ~w;
	endtask
endmodule // pcs_seq_model

// ### testbench.sv
// Self-checking bench for the program counter, stack and pointer unit
`timescale 1ns/1ps
module testbench;
	import pcs_pkg::*;
	localparam int ADV = 0, PCW = 1, CALL = 2, CW = 3, JUMP_REL_ACCUM = 4, JUMP_REL_SIGNED = 5;
	localparam int VEC = 6, RET = 7;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, win_sel = 1'b0, err, pready, pslverr;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
	logic        stack_reset_req, win_self, win_write_ok, win_extra_cycle;
	logic        seq_advance, seq_pcl_write, seq_call, seq_call_via_accum;
	logic        seq_jump_rel_accum, seq_jump_rel_signed, seq_vector;
	logic        seq_return;
	logic [7:0]  seq_pcl_data, seq_accum, lat;
	logic [10:0] seq_call_operand;
	logic [8:0]  seq_branch_operand;
	logic [14:0] seq_vector_addr, pc, ep, e;
	logic [1:0]  win_region;
	logic [15:0] win_target;
	logic [15:0] wa [10] = '{16'h0000, 16'h0001, 16'h0FFF, 16'h1000,
		16'h1FFF, 16'h2000, 16'h2050, 16'h29AF, 16'h8000, 16'hFFFF};
	int          failures = 0, n_compared = 0, cyc = 0, k, i;
	pcs_core uut (.*);
	pcs_seq_model seq (.*);
	initial begin
		forever #5 pclk = ~pclk;
	end
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			give_verdict;
		end
	end
	task automatic give_verdict;
		$display("compared %0d, failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bad(input string m);
		failures++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	// One APB transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= {18'h0, a, 2'h0};
		pwrite <= wr;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk_reg(input logic [11:0] a, input logic [31:0] x,
		input logic ee);
		apb(1'b0, a, 32'h0);
		n_compared++;
		if (rd !== x || err !== ee) bad("register read");
	endtask
	task automatic chk_pc(input logic [14:0] x);
		#1;
		n_compared++;
		if (pc !== x) bad("program counter");
	endtask
	function automatic logic [17:0] wexp(input logic [15:0] a);
		int o;
		o = a - LIN_BASE;
		if (a <= TRAD_END) return {PCS_RGN_TRAD, a};
		if (a >= PROG_BASE) return {PCS_RGN_PROG, 1'b0, a[14:0]};
		if (a >= LIN_BASE && a <= LIN_END)
			return {PCS_RGN_LIN, 16'(o / 80 * 128 + 32 + o % 80)};
		return {PCS_RGN_RSVD, a};
	endfunction
	task automatic chk_win(input logic [15:0] a, input logic s);
		logic [17:0] x;
		x = wexp(a);
		win_sel <= s;
		apb(1'b1, s ? IDX_PTR1_LO : IDX_PTR0_LO, {24'h0, a[7:0]});
		apb(1'b1, s ? IDX_PTR1_HI : IDX_PTR0_HI, {24'h0, a[15:8]});
		#1;
		n_compared++;
		if (win_region !== x[17:16] || win_self !== (a < 16'h2) ||
			(x[17:16] != PCS_RGN_RSVD && win_target !== x[15:0]))
			bad("window decode");
	endtask
	function automatic logic [14:0] nxt(int k, logic [14:0] p,
		logic [14:0] a, logic [7:0] w);
		case (k)
			ADV: return p + 15'h1;
			CALL: return {lat[6:3], a[10:0]};
			JUMP_REL_ACCUM: return p + 15'h1 + w;
			JUMP_REL_SIGNED: return p + 15'h1 + {{6{a[8]}}, a[8:0]};
			VEC: return a;
			default: return {lat[6:0], w};
		endcase
	endfunction
	task automatic op(input int k, input logic [14:0] a, input logic [7:0] w);
		seq.go(k, a, w);
		ep = nxt(k, ep, a, w);
		chk_pc(ep);
	endtask
	initial begin
		rd = $urandom(32'h1C46790D);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		ep = 15'h0;
		chk_pc(ep);
		chk_reg(IDX_STK_IDX, 32'h1F, 1'b0);
		chk_reg(12'hFEC, 32'h0, 1'b1);
		apb(1'b1, IDX_FLAGS_SAV, 32'hFF);
		chk_reg(IDX_FLAGS_SAV, 32'h07, 1'b0);
		lat = 8'($urandom) & 8'h7F;
		apb(1'b1, IDX_PC_HIGH_LATCH, {24'h0, lat});
		apb(1'b1, IDX_PCL, 32'h3C);
		ep = {lat[6:0], 8'h3C};
		chk_pc(ep);
		chk_reg(IDX_PCL, 32'h3C, 1'b0);
		op(PCW, 15'h0, 8'($urandom));
		e = ep + 15'h1;
		op(CALL, 15'($urandom), 8'h0);
		chk_reg(IDX_STK_IDX, 32'h0, 1'b0);
		chk_reg(IDX_TOS_LO, {24'h0, e[7:0]}, 1'b0);
		chk_reg(IDX_TOS_HI, {25'h0, e[14:8]}, 1'b0);
		chk_reg(IDX_PC_HIGH_LATCH, {24'h0, lat}, 1'b0);
		op(CW, 15'h0, 8'($urandom));
		// Interrupt pushes the current count, a return restores it
		e = ep;
		op(VEC, 15'($urandom), 8'h0);
		seq.go(RET, 15'h0, 8'h0);
		ep = e;
		chk_pc(ep);
		chk_reg(IDX_STK_IDX, 32'h1, 1'b0);
		// Seventeenth level wraps onto entry zero
		apb(1'b1, IDX_STK_IDX, 32'hE);
		op(CALL, 15'h0123, 8'h0);
		e = ep + 15'h1;
		op(CALL, 15'h0456, 8'h0);
		chk_reg(IDX_TOS_LO, {24'h0, e[7:0]}, 1'b0);
		chk_reg(IDX_CAUSE, 32'h80, 1'b0);
		// Overflow then underflow with the error reset enabled
		apb(1'b1, IDX_CAUSE, 32'h0);
		apb(1'b1, IDX_CTRL, 32'h1);
		for (k = 0; k < 2; k++) begin
			apb(1'b1, IDX_STK_IDX, k ? 32'h0 : 32'hF);
			seq.go(k ? RET : CALL, 15'h0, 8'h0);
			repeat (2) @(posedge pclk);
			ep = 15'h0;
			chk_pc(ep);
			chk_reg(IDX_STK_IDX, 32'h1F, 1'b0);
			chk_reg(IDX_CAUSE, k ? 32'h40 : 32'h80, 1'b0);
			apb(1'b1, IDX_CAUSE, 32'h0);
		end
		op(PCW, 15'h0, 8'hF0);
		op(JUMP_REL_ACCUM, 15'h0, 8'h20);
		op(JUMP_REL_SIGNED, 15'h01F0, 8'h0);
		// Random stack-free loads; stack ops would trip the error reset
		for (i = 0; i < 40; i++) begin
			k = $urandom_range(3, 0);
			if (k > 1) k += 2;
			op(k, 15'($urandom), 8'($urandom));
		end
		for (i = 0; i < 16; i++)
			chk_win(i < 10 ? wa[i] : 16'($urandom), i[0]);
		give_verdict;
	end
endmodule // testbench
bind pcs_core pcs_core_asserts chk (.*);
